//--- rtl/io_stack_perf_counters.sv
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - four programmable 48-bit event counters
// - counter step at most seven bits
// - flow-class filter: posted, non-posted, completions
// - express stack channels: ports, remap unit
// - copy stack channels: engine, links, remap
// - twelve-bit threshold for counter comparison
// - free-running counters ignore all writes
// - counting pauses while stack powered down
// - 36-bit clock counter, upper bits zero
// - inbound four-byte words counted per port
// - outbound four-byte words counted per port
// - input utilisation cycles counted per port
// - output utilisation cycles counted per port
// - low-power ports count as utilised in both directions
// - separate free counters for each port
// - lane position picks partition zero or two in x8, lane bits 3:2 in x4
// - filter fields reset zero, read back
module io_stack_perf_counters (
   input  wire logic                           I_CLK,
   input  wire logic                           I_RST,
   input  wire logic                           I_WB_CYC,
   input  wire logic                           I_WB_STB,
   input  wire logic                           I_WB_WE,
   input  wire logic [perf_pkg::ADR_W-1:0]     I_WB_ADR,
   input  wire logic [3:0]                     I_WB_SEL,
   input  wire logic [31:0]                    I_WB_DAT,
   output logic      [31:0]                    O_WB_DAT,
   output logic                                O_WB_ACK,
   input  wire logic                           I_COPY_STACK,
   input  wire logic [1:0]                     I_LANE_CFG,
   input  wire logic                           I_PWR_DOWN,
   input  wire perf_pkg::evt_t [perf_pkg::NUM_EVT-1:0]  I_EVT,
   input  wire perf_pkg::port_t [perf_pkg::NUM_PORT-1:0] I_PORT
);

   typedef struct packed {
      perf_pkg::ctl_t [perf_pkg::NUM_CTR-1:0]                    ctl;
      logic [perf_pkg::NUM_CTR-1:0][perf_pkg::CTR_W-1:0]         ctr;
      logic [perf_pkg::FREE_W-1:0]                               ioclk;
      logic [perf_pkg::NUM_PORT-1:0][perf_pkg::FREE_W-1:0]       bw_in;
      logic [perf_pkg::NUM_PORT-1:0][perf_pkg::FREE_W-1:0]       bw_out;
      logic [perf_pkg::NUM_PORT-1:0][perf_pkg::FREE_W-1:0]       util_in;
      logic [perf_pkg::NUM_PORT-1:0][perf_pkg::FREE_W-1:0]       util_out;
      logic                                                      ack;
      logic [31:0]                                               rdat;
   } state_t;

   state_t state_ff;
   state_t nxt_state;

   function automatic logic [31:0] merge(input logic [31:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [3:0]  sel);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // one half of a 64-bit register, merged per byte lane
   function automatic logic [63:0] merge64(input logic [63:0] old_v,
                                           input logic        hi,
                                           input logic [31:0] new_w,
                                           input logic [3:0]  sel);
      logic [63:0] res;
      res = old_v;
      if (hi) begin
         res[63:32] = merge(old_v[63:32], new_w, sel);
      end else begin
         res[31:0] = merge(old_v[31:0], new_w, sel);
      end
      return res;
   endfunction : merge64

   // reserved bits 63:47 are not stored and read as zero
   function automatic logic [63:0] pack_ctl(input perf_pkg::ctl_t c);
      logic [63:0] v;
      v = 64'h0;
      v[perf_pkg::FC_LSB +: perf_pkg::FC_W]       = c.flow_class_filter;
      v[perf_pkg::CH_LSB +: perf_pkg::CH_W]       = c.channel_filter;
      v[perf_pkg::THR_LSB +: perf_pkg::THR_W]     = c.threshold;
      v[perf_pkg::EN_BIT]                         = c.enable;
      v[perf_pkg::EVSEL_LSB +: perf_pkg::EVSEL_W] = c.event_select;
      return v;
   endfunction : pack_ctl

   function automatic perf_pkg::ctl_t unpack_ctl(input logic [63:0] v);
      perf_pkg::ctl_t c;
      c.flow_class_filter = v[perf_pkg::FC_LSB +: perf_pkg::FC_W];
      c.channel_filter    = v[perf_pkg::CH_LSB +: perf_pkg::CH_W];
      c.threshold         = v[perf_pkg::THR_LSB +: perf_pkg::THR_W];
      c.enable            = v[perf_pkg::EN_BIT];
      c.event_select      = v[perf_pkg::EVSEL_LSB +: perf_pkg::EVSEL_W];
      return c;
   endfunction : unpack_ctl

   // partition of a lane-attributed event
   function automatic logic [perf_pkg::CH_W-1:0] lane_partition(
         input logic [1:0]                  cfg,
         input logic [perf_pkg::LANE_W-1:0] lane);
      logic [perf_pkg::CH_W-1:0] p;
      p = perf_pkg::PARTITION_ZERO;
      case (cfg)
         perf_pkg::LANES_X16: begin
            p = perf_pkg::PARTITION_ZERO;
         end
         perf_pkg::LANES_X8: begin
            if (lane >= perf_pkg::X8_SECOND_LANE) begin
               p = perf_pkg::PARTITION_TWO;
            end
         end
         perf_pkg::LANES_X4: begin
            p = {6'h00, lane[3:2]};
         end
         default: begin
            p = perf_pkg::PARTITION_ZERO;
         end
      endcase
      return p;
   endfunction : lane_partition

   logic                           req;
   logic                           wr;
   logic [perf_pkg::REG_W-1:0]     reg_no;
   logic                           hi_half;

   assign req     = I_WB_CYC & I_WB_STB & ~state_ff.ack;
   assign wr      = req & I_WB_WE;
   assign reg_no  = I_WB_ADR[7:3];
   assign hi_half = I_WB_ADR[2];

   always_comb begin
      logic [63:0]                 rd64;
      logic [63:0]                 cur;
      logic [31:0]                 half;
      perf_pkg::evt_t              ev;
      logic                        ev_ok;
      logic                        fc_ok;
      logic                        ch_ok;
      logic [perf_pkg::CH_W-1:0]   chan_eff;
      logic [perf_pkg::CH_W-1:0]   ch_max;
      logic [perf_pkg::INC_W-1:0]  amount;
      rd64     = 64'h0;
      cur      = 64'h0;
      half     = 32'h0;
      ev       = '0;
      ev_ok    = 1'b0;
      fc_ok    = 1'b0;
      ch_ok    = 1'b0;
      chan_eff = '0;
      ch_max   = '0;
      amount   = '0;
      nxt_state = state_ff;

      // hold all counts while powered down
      if (!I_PWR_DOWN) begin
         nxt_state.ioclk = state_ff.ioclk + 36'h1;
         for (int p = 0; p < perf_pkg::NUM_PORT; p++) begin
            nxt_state.bw_in[p] = state_ff.bw_in[p]
               + 36'(I_PORT[p].in_words);
            nxt_state.bw_out[p] = state_ff.bw_out[p]
               + 36'(I_PORT[p].out_words);
            if (I_PORT[p].in_busy | I_PORT[p].low_power) begin
               nxt_state.util_in[p] = state_ff.util_in[p] + 36'h1;
            end
            if (I_PORT[p].out_busy | I_PORT[p].low_power) begin
               nxt_state.util_out[p] = state_ff.util_out[p] + 36'h1;
            end
         end

         for (int c = 0; c < perf_pkg::NUM_CTR; c++) begin
            ev_ok = state_ff.ctl[c].enable
               && (state_ff.ctl[c].event_select
                   < perf_pkg::EVSEL_W'(perf_pkg::NUM_EVT));
            ev = I_EVT[state_ff.ctl[c].event_select[1:0]];
            fc_ok = !ev.fc_applies
               || (ev.flow_class == state_ff.ctl[c].flow_class_filter);
            chan_eff = ev.by_lane ? lane_partition(I_LANE_CFG, ev.lane)
                                  : ev.channel;
            ch_max = I_COPY_STACK ? perf_pkg::CH_COPY_MAX
                                  : perf_pkg::CH_EXPRESS_MAX;
            ch_ok = !ev.ch_applies
               || ((chan_eff == state_ff.ctl[c].channel_filter)
                   && (state_ff.ctl[c].channel_filter <= ch_max));
            if (state_ff.ctl[c].threshold == 12'h000) begin
               amount = ev.inc;
            end else if (12'(ev.inc) >= state_ff.ctl[c].threshold) begin
               amount = 7'h01;
            end else begin
               amount = 7'h00;
            end
            if (ev_ok && fc_ok && ch_ok) begin
               nxt_state.ctr[c] = state_ff.ctr[c] + 48'(amount);
            end
         end
      end

      // register read selection; unmapped numbers read zero
      case (reg_no)
         perf_pkg::REG_CTL: begin
            rd64 = pack_ctl(state_ff.ctl[0]);
         end
         perf_pkg::REG_CTL + 5'h01: begin
            rd64 = pack_ctl(state_ff.ctl[1]);
         end
         perf_pkg::REG_CTL + 5'h02: begin
            rd64 = pack_ctl(state_ff.ctl[2]);
         end
         perf_pkg::REG_CTL + 5'h03: begin
            rd64 = pack_ctl(state_ff.ctl[3]);
         end
         perf_pkg::REG_CTR: begin
            rd64 = {16'h0000, state_ff.ctr[0]};
         end
         perf_pkg::REG_CTR + 5'h01: begin
            rd64 = {16'h0000, state_ff.ctr[1]};
         end
         perf_pkg::REG_CTR + 5'h02: begin
            rd64 = {16'h0000, state_ff.ctr[2]};
         end
         perf_pkg::REG_CTR + 5'h03: begin
            rd64 = {16'h0000, state_ff.ctr[3]};
         end
         perf_pkg::REG_IOCLK: begin
            rd64 = {28'h0000000, state_ff.ioclk};
         end
         perf_pkg::REG_BW_IN: begin
            rd64 = {28'h0000000, state_ff.bw_in[0]};
         end
         perf_pkg::REG_BW_IN + 5'h01: begin
            rd64 = {28'h0000000, state_ff.bw_in[1]};
         end
         perf_pkg::REG_BW_IN + 5'h02: begin
            rd64 = {28'h0000000, state_ff.bw_in[2]};
         end
         perf_pkg::REG_BW_IN + 5'h03: begin
            rd64 = {28'h0000000, state_ff.bw_in[3]};
         end
         perf_pkg::REG_BW_OUT: begin
            rd64 = {28'h0000000, state_ff.bw_out[0]};
         end
         perf_pkg::REG_BW_OUT + 5'h01: begin
            rd64 = {28'h0000000, state_ff.bw_out[1]};
         end
         perf_pkg::REG_BW_OUT + 5'h02: begin
            rd64 = {28'h0000000, state_ff.bw_out[2]};
         end
         perf_pkg::REG_BW_OUT + 5'h03: begin
            rd64 = {28'h0000000, state_ff.bw_out[3]};
         end
         perf_pkg::REG_UTIL_IN: begin
            rd64 = {28'h0000000, state_ff.util_in[0]};
         end
         perf_pkg::REG_UTIL_IN + 5'h01: begin
            rd64 = {28'h0000000, state_ff.util_in[1]};
         end
         perf_pkg::REG_UTIL_IN + 5'h02: begin
            rd64 = {28'h0000000, state_ff.util_in[2]};
         end
         perf_pkg::REG_UTIL_IN + 5'h03: begin
            rd64 = {28'h0000000, state_ff.util_in[3]};
         end
         perf_pkg::REG_UTIL_OUT: begin
            rd64 = {28'h0000000, state_ff.util_out[0]};
         end
         perf_pkg::REG_UTIL_OUT + 5'h01: begin
            rd64 = {28'h0000000, state_ff.util_out[1]};
         end
         perf_pkg::REG_UTIL_OUT + 5'h02: begin
            rd64 = {28'h0000000, state_ff.util_out[2]};
         end
         perf_pkg::REG_UTIL_OUT + 5'h03: begin
            rd64 = {28'h0000000, state_ff.util_out[3]};
         end
         default: begin
            rd64 = 64'h0;
         end
      endcase

      // software writes win over counting in the same cycle
      // free-running counters take no writes
      if (wr) begin
         case (reg_no)
            perf_pkg::REG_CTL: begin
               nxt_state.ctl[0] = unpack_ctl(merge64(
                  pack_ctl(state_ff.ctl[0]), hi_half, I_WB_DAT, I_WB_SEL));
            end
            perf_pkg::REG_CTL + 5'h01: begin
               nxt_state.ctl[1] = unpack_ctl(merge64(
                  pack_ctl(state_ff.ctl[1]), hi_half, I_WB_DAT, I_WB_SEL));
            end
            perf_pkg::REG_CTL + 5'h02: begin
               nxt_state.ctl[2] = unpack_ctl(merge64(
                  pack_ctl(state_ff.ctl[2]), hi_half, I_WB_DAT, I_WB_SEL));
            end
            perf_pkg::REG_CTL + 5'h03: begin
               nxt_state.ctl[3] = unpack_ctl(merge64(
                  pack_ctl(state_ff.ctl[3]), hi_half, I_WB_DAT, I_WB_SEL));
            end
            perf_pkg::REG_CTR: begin
               cur = merge64({16'h0000, state_ff.ctr[0]}, hi_half,
                             I_WB_DAT, I_WB_SEL);
               nxt_state.ctr[0] = cur[perf_pkg::CTR_W-1:0];
            end
            perf_pkg::REG_CTR + 5'h01: begin
               cur = merge64({16'h0000, state_ff.ctr[1]}, hi_half,
                             I_WB_DAT, I_WB_SEL);
               nxt_state.ctr[1] = cur[perf_pkg::CTR_W-1:0];
            end
            perf_pkg::REG_CTR + 5'h02: begin
               cur = merge64({16'h0000, state_ff.ctr[2]}, hi_half,
                             I_WB_DAT, I_WB_SEL);
               nxt_state.ctr[2] = cur[perf_pkg::CTR_W-1:0];
            end
            perf_pkg::REG_CTR + 5'h03: begin
               cur = merge64({16'h0000, state_ff.ctr[3]}, hi_half,
                             I_WB_DAT, I_WB_SEL);
               nxt_state.ctr[3] = cur[perf_pkg::CTR_W-1:0];
            end
            default: begin
               cur = 64'h0;
            end
         endcase
      end

      half = hi_half ? rd64[63:32] : rd64[31:0];
      nxt_state.ack  = req;
      nxt_state.rdat = (req && !I_WB_WE) ? half : 32'h00000000;
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         state_ff.ctl      <= {perf_pkg::NUM_CTR{perf_pkg::CTL_RST}};
         state_ff.ctr      <= {perf_pkg::NUM_CTR{perf_pkg::CTR_RST}};
         state_ff.ioclk    <= perf_pkg::FREE_RST;
         state_ff.bw_in    <= {perf_pkg::NUM_PORT{perf_pkg::FREE_RST}};
         state_ff.bw_out   <= {perf_pkg::NUM_PORT{perf_pkg::FREE_RST}};
         state_ff.util_in  <= {perf_pkg::NUM_PORT{perf_pkg::FREE_RST}};
         state_ff.util_out <= {perf_pkg::NUM_PORT{perf_pkg::FREE_RST}};
         state_ff.ack      <= 1'b0;
         state_ff.rdat     <= 32'h00000000;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign O_WB_DAT = state_ff.rdat;
   assign O_WB_ACK = state_ff.ack;

endmodule : io_stack_perf_counters

//--- rtl/perf_pkg.sv
package perf_pkg;

   localparam int NUM_CTR  = 4;
   localparam int NUM_PORT = 4;
   localparam int NUM_EVT  = 4;

   localparam int CTR_W   = 48;
   localparam int FREE_W  = 36;
   localparam int INC_W   = 7;
   localparam int THR_W   = 12;
   localparam int CH_W    = 8;
   localparam int FC_W    = 3;
   localparam int EVSEL_W = 8;
   localparam int BW_W    = 4;
   localparam int LANE_W  = 4;
   localparam int ADR_W   = 8;
   localparam int REG_W   = 5;

   // 64-bit control register field positions
   localparam int FC_LSB    = 44;
   localparam int CH_LSB    = 36;
   localparam int THR_LSB   = 24;
   localparam int EN_BIT    = 22;
   localparam int EVSEL_LSB = 0;

   // flow class codes
   localparam logic [FC_W-1:0] FC_POSTED    = 3'h0;
   localparam logic [FC_W-1:0] FC_NONPOSTED = 3'h1;
   localparam logic [FC_W-1:0] FC_COMPL     = 3'h2;

   // highest assigned channel code per stack kind
   localparam logic [CH_W-1:0] CH_EXPRESS_MAX = 8'h04;
   localparam logic [CH_W-1:0] CH_COPY_MAX    = 8'h05;

   // lane configurations and partitions
   localparam logic [1:0]      LANES_X16      = 2'h0;
   localparam logic [1:0]      LANES_X8       = 2'h1;
   localparam logic [1:0]      LANES_X4       = 2'h2;
   localparam logic [CH_W-1:0] PARTITION_ZERO = 8'h00;
   localparam logic [CH_W-1:0] PARTITION_TWO  = 8'h02;
   localparam logic [LANE_W-1:0] X8_SECOND_LANE = 4'h8;

   // register numbers; byte address = number * 8, +4 for bits 63:32
   localparam logic [REG_W-1:0] REG_CTL      = 5'h00;
   localparam logic [REG_W-1:0] REG_CTR      = 5'h04;
   localparam logic [REG_W-1:0] REG_IOCLK    = 5'h08;
   localparam logic [REG_W-1:0] REG_BW_IN    = 5'h09;
   localparam logic [REG_W-1:0] REG_BW_OUT   = 5'h0D;
   localparam logic [REG_W-1:0] REG_UTIL_IN  = 5'h11;
   localparam logic [REG_W-1:0] REG_UTIL_OUT = 5'h15;

   typedef struct packed {
      logic [FC_W-1:0]    flow_class_filter;
      logic [CH_W-1:0]    channel_filter;
      logic [THR_W-1:0]   threshold;
      logic               enable;
      logic [EVSEL_W-1:0] event_select;
   } ctl_t;

   localparam ctl_t CTL_RST = '0;
   localparam logic [CTR_W-1:0]  CTR_RST  = 48'h0;
   localparam logic [FREE_W-1:0] FREE_RST = 36'h0;

   typedef struct packed {
      logic [INC_W-1:0]  inc;
      logic [FC_W-1:0]   flow_class;
      logic [CH_W-1:0]   channel;
      logic [LANE_W-1:0] lane;
      logic              fc_applies;
      logic              ch_applies;
      logic              by_lane;
   } evt_t;

   typedef struct packed {
      logic [BW_W-1:0] in_words;
      logic [BW_W-1:0] out_words;
      logic            in_busy;
      logic            out_busy;
      logic            low_power;
   } port_t;

endpackage : perf_pkg

//--- tb/io_stack_perf_counters_tb.sv
`timescale 1ns/1ps
module io_stack_perf_counters_tb;
   logic                  clk   = 1'b0;
   logic                  rst   = 1'b1;
   logic                  cyc   = 1'b0;
   logic                  we    = 1'b0;
   logic                  pwr   = 1'b0;
   logic                  run   = 1'b0;
   logic                  copy  = 1'b0;
   logic [3:0]            sel   = 4'hF;
   logic [7:0]            adr   = 8'h00;
   logic [31:0]           wdat  = 32'h0;
   logic [1:0]            lanes = perf_pkg::LANES_X8;
   logic [31:0]           rdat;
   logic                  ack;
   // step 5, non-posted, lane 8, all filters apply
   perf_pkg::evt_t        tmpl  = {7'h05, 3'h1, 8'h07, 4'h8, 3'h7};
   perf_pkg::evt_t  [3:0] evt;
   perf_pkg::port_t [3:0] port;
   int                    fail_count = 0;
   int                    compares   = 0;

   always #25 clk = ~clk;

   io_stack_perf_counters i_dut (
      .I_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(cyc),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
      .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_COPY_STACK(copy),
      .I_LANE_CFG(lanes), .I_PWR_DOWN(pwr), .I_EVT(evt), .I_PORT(port)
   );
   traffic_model i_model (
      .i_clk(clk), .i_run(run), .i_tmpl(tmpl), .o_evt(evt), .o_port(port)
   );

   task automatic end_sim;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1) begin
         n++;
         if (n > 8) begin
            fail_count++;
            end_sim();
         end
         @(posedge clk);
      end
      q = rdat;
      cyc <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      compares++;
      if (q !== e) begin
         fail_count++;
         $display("[ERR] reg %h expected %h seen %h", a, e, q);
      end
   endtask : rd_chk

   task automatic traffic(input int n);
      run <= 1'b1;
      repeat (n) @(posedge clk);
      run <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : traffic

   task automatic chk_free(input int n);
      for (int p = 0; p < 4; p++) begin
         rd_chk(8'h48 + 8'(p * 8), 32'((p + 1) * n));
         rd_chk(8'h68 + 8'(p * 8), 32'((4 - p) * n));
         rd_chk(8'h88 + 8'(p * 8), 32'(p == 0 || p == 3 ? n : 0));
         rd_chk(8'hA8 + 8'(p * 8), 32'(p == 1 || p == 3 ? n : 0));
      end
   endtask : chk_free

   task automatic t_reset;
      for (int a = 0; a < 256; a += 4)
         if (a != 'h40)
            rd_chk(8'(a), 32'h0);
   endtask : t_reset

   task automatic t_ctl;
      wr(8'h08, 32'hFFFFFFFF);
      wr(8'h0C, 32'h00007FFF);
      wr(8'hC8, 32'hFFFFFFFF);
      // only the lowest byte lane is written
      sel <= 4'h1;
      wr(8'h10, 32'hFFFFFFFF);
      sel <= 4'hF;
      rd_chk(8'h08, 32'hFF4000FF);
      rd_chk(8'h0C, 32'h00007FFF);
      rd_chk(8'hC8, 32'h0);
      rd_chk(8'h10, 32'h000000FF);
   endtask : t_ctl

   task automatic t_free;
      wr(8'h48, 32'hFFFFFFFF);
      wr(8'h40, 32'hFFFFFFFF);
      traffic(10);
      chk_free(10);
   endtask : t_free

   task automatic t_pwr;
      logic [31:0] q;
      pwr <= 1'b1;
      traffic(10);
      pwr <= 1'b0;
      chk_free(10);
      bus(1'b0, 8'h40, 32'h0, q);
      traffic(10);
      chk_free(20);
   endtask : t_pwr

   task automatic t_copy;
      // step 3, channel 5, only the channel filter applies
      tmpl <= {7'h03, 3'h0, 8'h05, 4'h0, 3'h2};
      wr(8'h04, 32'h00000050);
      wr(8'h20, 32'h0);
      wr(8'h24, 32'h0);
      traffic(10);
      rd_chk(8'h20, 32'h0);
      copy <= 1'b1;
      traffic(10);
      rd_chk(8'h20, 32'h1E);
   endtask : t_copy

   task automatic t_event;
      logic [31:0] hi [4] = '{32'h1020, 32'h2020, 32'h1000, 32'h1020};
      int          e1 [4] = '{49, 0, 0, 10};
      int          e2 [4] = '{49, 0, 50, 10};
      for (int c = 0; c < 4; c++) begin
         wr(8'(c * 8), c == 3 ? 32'h05400000 : 32'h00400000);
         wr(8'(c * 8 + 4), hi[c]);
      end
      wr(8'h20, 32'hFFFFFFFF);
      wr(8'h24, 32'h0000FFFF);
      traffic(10);
      for (int c = 0; c < 4; c++)
         rd_chk(8'h20 + 8'(c * 8), 32'(e1[c]));
      rd_chk(8'h24, 32'h0);
      lanes <= perf_pkg::LANES_X16;
      traffic(10);
      for (int c = 0; c < 4; c++)
         rd_chk(8'h20 + 8'(c * 8), 32'(e2[c]));
   endtask : t_event

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_ctl();
      t_free();
      t_pwr();
      t_event();
      t_copy();
      end_sim();
   end
endmodule : io_stack_perf_counters_tb

//--- tb/perf_monitor.sv
`timescale 1ns/1ps
module perf_monitor (
   input wire logic                       I_CLK,
   input wire logic                       I_RST,
   input wire logic                       I_WB_CYC,
   input wire logic                       I_WB_STB,
   input wire logic                       I_WB_WE,
   input wire logic [perf_pkg::ADR_W-1:0] I_WB_ADR,
   input wire logic                       I_PWR_DOWN,
   input wire logic [31:0]                O_WB_DAT,
   input wire logic                       O_WB_ACK
);
   logic [35:0] clk_cnt_ff;
   logic [31:0] cnt_lo;
   logic        take;
   logic        rd_hi;
   logic [4:0]  rnum;

   assign take   = I_WB_CYC && I_WB_STB && !O_WB_ACK;
   assign rd_hi  = take && !I_WB_WE && I_WB_ADR[2];
   assign rnum   = I_WB_ADR[7:3];
   assign cnt_lo = clk_cnt_ff[31:0];

   // reference io clock count, frozen in power down
   always_ff @(posedge I_CLK) begin
      if (I_RST)
         clk_cnt_ff <= 36'h0;
      else if (!I_PWR_DOWN)
         clk_cnt_ff <= clk_cnt_ff + 36'h1;
   end

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   ack_latency_a:
      assert property (take |=> O_WB_ACK) else $error("ack missing");
   ack_pulse_a:
      assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack too long");
   ack_cause_a:
      assert property ($rose(O_WB_ACK) |-> $past(take))
      else $error("ack without request");
   ioclk_track_a:
      assert property (take && !I_WB_WE && I_WB_ADR[7:2] == 6'h10
         |=> O_WB_DAT == $past(cnt_lo)) else $error("clock count wrong");
   free_upper_a:
      assert property (rd_hi && rnum inside {[5'h08:5'h18]}
         |=> O_WB_DAT[31:4] == 28'h0) else $error("free upper not zero");
   ctr_upper_a:
      assert property (rd_hi && rnum inside {[5'h04:5'h07]}
         |=> O_WB_DAT[31:16] == 16'h0) else $error("counter upper set");
   ctl_upper_a:
      assert property (rd_hi && rnum < 5'h04
         |=> O_WB_DAT[31:15] == 17'h0) else $error("ctl reserved set");
   unmapped_zero_a:
      assert property (take && !I_WB_WE && rnum > 5'h18
         |=> O_WB_DAT == 32'h0) else $error("unmapped read not zero");
endmodule : perf_monitor

bind io_stack_perf_counters perf_monitor i_mon (
   .I_CLK(I_CLK), .I_RST(I_RST), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
   .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_PWR_DOWN(I_PWR_DOWN),
   .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK)
);

//--- tb/traffic_model.sv
`timescale 1ns/1ps
module traffic_model (
   input  wire logic              i_clk,
   input  wire logic              i_run,
   input  wire perf_pkg::evt_t    i_tmpl,
   output perf_pkg::evt_t  [3:0]  o_evt,
   output perf_pkg::port_t [3:0]  o_port
);
   logic active_ff = 1'b0;

   always_ff @(posedge i_clk) begin
      active_ff <= i_run;
   end

   always_comb begin
      for (int e = 0; e < 4; e++) begin
         o_evt[e] = active_ff ? i_tmpl : ~i_tmpl;
         if (!active_ff)
            o_evt[e].inc = 7'h00;
      end
      for (int p = 0; p < 4; p++) begin
         o_port[p] = '0;
         if (active_ff) begin
            o_port[p].in_words  = 4'(p + 1);
            o_port[p].out_words = 4'(4 - p);
            o_port[p].in_busy   = (p == 0);
            o_port[p].out_busy  = (p == 1);
            o_port[p].low_power = (p == 3);
         end
      end
   end
endmodule : traffic_model
